// >>> hw/fsa_pkg.sv
// shared constants and types for the fault status and acknowledge block
package fsa_pkg;
	localparam int unsigned FSA_CLK_HZ = 50_000_000;
	localparam int unsigned FSA_BLINK_HALF_MS = 250;
	localparam int unsigned FSA_BLINK_HALF_CYC = FSA_CLK_HZ / 1000 * FSA_BLINK_HALF_MS;
	localparam int unsigned FSA_STARTUP_CYC = 1024;
	localparam int unsigned FSA_LOWV_MV = 11000;
	localparam logic [15:0] FSA_STEP_LIM = 16'h0010;
	localparam logic [15:0] FSA_DIFF_RST = 16'h0000;
	localparam logic [7:0] FSA_CTRL_OFF = 8'h00;
	localparam logic [7:0] FSA_CMD_OFF = 8'h04;
	localparam logic [7:0] FSA_CFG_OFF = 8'h08;
	localparam logic [7:0] FSA_LEVEL_OFF = 8'h0C;
	localparam logic [7:0] FSA_STATUS_OFF = 8'h10;
	localparam int unsigned FSA_CTRL_AUTO = 0;
	localparam int unsigned FSA_CTRL_ACCESS = 1;
	localparam int unsigned FSA_CMD_ACK = 0;
	localparam int unsigned FSA_CMD_LAUNCH = 1;
	localparam int unsigned FSA_CMD_UPD_OK = 2;
	localparam logic [1:0] FSA_CTRL_RST = 2'h0;
	localparam logic [7:0] FSA_CFG_RST = 8'h00;
	localparam logic [1:0] FSA_LEVEL_RST = 2'h0;
	localparam logic [1:0] FSA_LEVEL_MASTER = 2'h3;
	localparam logic [3:0] FSA_DEV_NONE = 4'h0;
	localparam logic [3:0] FSA_DEV_UNKNOWN = 4'hF;
	localparam logic [31:0] FSA_ZERO = 32'h0000_0000;
	typedef enum {FSA_UPD_IDLE, FSA_UPD_WAIT} fsa_upd_t;
	function automatic logic fsa_hit(input logic [31:0] addr, input logic [7:0] off);
		return (addr[31:8] == 24'h00_0000) && (addr[7:0] == off);
	endfunction
endpackage

// >>> hw/fsa_edge.sv
// rising edge detector with a registered one-cycle pulse
module fsa_edge
	import fsa_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic level,
	output logic pulse
);
	logic prev_q;
	logic pulse_q;
	// prev starts high so a source held through reset gives no edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prev_q <= 1'b1;
			pulse_q <= 1'b0;
		end else if (clk_en) begin
			prev_q <= level;
			pulse_q <= level & ~prev_q;
		end
	end
	assign pulse = pulse_q;
endmodule // fsa_edge

// >>> hw/fsa_blink.sv
// blink phase generator for the status lamp
module fsa_blink
	import fsa_pkg::*;
#(
	parameter int unsigned HALF_CYC = FSA_BLINK_HALF_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	output logic phase
);
	logic [23:0] cnt_q;
	logic ph_q;
	logic wrap_w;
	assign wrap_w = (cnt_q == 24'(HALF_CYC - 1));
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_q <= 24'h00_0000;
			ph_q <= 1'b1;
		end else if (clk_en) begin
			cnt_q <= wrap_w ? 24'h00_0000 : cnt_q + 24'h00_0001;
			ph_q <= wrap_w ? ~ph_q : ph_q;
		end
	end
	assign phase = ph_q;
endmodule // fsa_blink

// >>> hw/fsa_top.sv
// fault latching, acknowledge, status lamp and update sequencing
//
// The implementer's own choices: the APB register port and the address map.
module fsa_top
	import fsa_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = FSA_BLINK_HALF_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic btn_open,
	input wire logic btn_close,
	input wire logic reset_in,
	input wire logic supply_low,
	input wire logic step_cmd,
	input wire logic step_fb,
	input wire logic over_temp,
	input wire logic over_current,
	input wire logic ref_fail,
	input wire logic ref_done,
	input wire logic overload,
	input wire logic critical,
	input wire logic [3:0] actuator_id,
	output logic lamp_red,
	output logic lamp_green,
	output logic error_out,
	output logic error_led,
	output logic restart_req,
	output logic ref_run_start
);
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [1:0] ctrl_q;
	logic [7:0] cfg_q;
	logic [1:0] level_q;
	logic svc_q;
	logic sl_q;
	logic ot_q;
	logic lv_q;
	logic oc_q;
	logic rf_q;
	logic crit_q;
	logic warn_q;
	logic conf_q;
	logic ref_req_q;
	logic slow_q;
	logic refused_q;
	logic [10:0] su_cnt_q;
	logic [15:0] diff_q;
	fsa_upd_t upd_q;
	logic lamp_red_q;
	logic lamp_green_q;
	logic error_out_q;
	logic restart_q;
	logic ref_start_q;
	logic btn_p;
	logic rst_p;
	logic ph;

	// a flag sets on its cause; an accepted pulse clears it only once the cause is gone
	function automatic logic fsa_flag(input logic q, input logic cause, input logic ack);
		return cause | (q & ~(ack & ~cause));
	endfunction

	fsa_edge u_btn_edge (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.level(btn_open & btn_close),
		.pulse(btn_p)
	);

	fsa_edge u_rst_edge (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.level(reset_in),
		.pulse(rst_p)
	);

	fsa_blink #(
		.HALF_CYC(BLINK_HALF_CYC)
	) u_blink (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.phase(ph)
	);

	// bus decode
	logic setup_w;
	logic wr_w;
	logic hit_ctrl;
	logic hit_cmd;
	logic hit_cfg;
	logic hit_level;
	logic hit_status;
	logic hit_any;
	logic [31:0] status_w;
	logic [31:0] rdata_w;
	assign setup_w = psel & ~penable;
	assign wr_w = psel & penable & pready_q & pwrite;
	assign hit_ctrl = fsa_hit(paddr, FSA_CTRL_OFF);
	assign hit_cmd = fsa_hit(paddr, FSA_CMD_OFF);
	assign hit_cfg = fsa_hit(paddr, FSA_CFG_OFF);
	assign hit_level = fsa_hit(paddr, FSA_LEVEL_OFF);
	assign hit_status = fsa_hit(paddr, FSA_STATUS_OFF);
	assign hit_any = hit_ctrl | hit_cmd | hit_cfg | hit_level | hit_status;
	assign status_w = {18'h0_0000, lamp_green_q, lamp_red_q, upd_q == FSA_UPD_WAIT, refused_q,
		slow_q, ref_req_q, conf_q, warn_q, crit_q, rf_q, oc_q, lv_q, ot_q, sl_q};
	assign rdata_w = hit_ctrl ? {30'h0000_0000, ctrl_q} :
		hit_cfg ? {24'h00_0000, cfg_q} :
		hit_level ? {30'h0000_0000, level_q} :
		hit_status ? status_w : FSA_ZERO;

	// update command decode
	logic auto_w;
	logic refuse_w;
	logic launch_w;
	logic launch_ok;
	logic upd_ok_w;
	logic slverr_w;
	assign auto_w = ctrl_q[FSA_CTRL_AUTO];
	assign refuse_w = ctrl_q[FSA_CTRL_ACCESS] & (level_q != FSA_LEVEL_MASTER);
	assign launch_w = wr_w & hit_cmd & pwdata[FSA_CMD_LAUNCH];
	assign launch_ok = launch_w & ~refuse_w & (upd_q == FSA_UPD_IDLE);
	assign upd_ok_w = wr_w & hit_cmd & pwdata[FSA_CMD_UPD_OK] & (upd_q == FSA_UPD_WAIT);
	assign slverr_w = ~hit_any | (pwrite & hit_cmd & pwdata[FSA_CMD_LAUNCH] & refuse_w);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= FSA_ZERO;
		end else if (clk_en) begin
			pready_q <= setup_w;
			pslverr_q <= setup_w & slverr_w;
			prdata_q <= (setup_w & ~pwrite) ? rdata_w : FSA_ZERO;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_q <= FSA_CTRL_RST;
			cfg_q <= FSA_CFG_RST;
			level_q <= FSA_LEVEL_RST;
			svc_q <= 1'b0;
		end else if (clk_en) begin
			ctrl_q <= (wr_w & hit_ctrl) ? pwdata[1:0] : ctrl_q;
			cfg_q <= (wr_w & hit_cfg) ? pwdata[7:0] : cfg_q;
			level_q <= (wr_w & hit_level) ? pwdata[1:0] : level_q;
			svc_q <= wr_w & hit_cmd & pwdata[FSA_CMD_ACK];
		end
	end

	// acknowledge sources
	logic ack_err;
	logic ack_warn;
	logic ack_conf;
	assign ack_err = btn_p | rst_p | svc_q;
	assign ack_warn = (btn_p & ~auto_w) | rst_p;
	assign ack_conf = btn_p | rst_p;

	// step loss from commanded versus observed steps
	logic [15:0] diff_nx;
	logic [15:0] diff_abs;
	logic step_over;
	assign diff_nx = diff_q + {15'h0000, step_cmd} - {15'h0000, step_fb};
	assign diff_abs = diff_q[15] ? 16'(-diff_q) : diff_q;
	assign step_over = diff_abs > FSA_STEP_LIM;
	// the count that an acknowledge discards cannot hold the flag
	logic step_cause;
	assign step_cause = step_over & ~ack_err;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			diff_q <= FSA_DIFF_RST;
		end else if (clk_en) begin
			diff_q <= ack_err ? FSA_DIFF_RST : diff_nx;
		end
	end

	// start-up supply watch
	logic su_busy;
	assign su_busy = su_cnt_q != 11'(FSA_STARTUP_CYC);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			su_cnt_q <= 11'h000;
			slow_q <= 1'b0;
		end else if (clk_en) begin
			su_cnt_q <= su_busy ? su_cnt_q + 11'h001 : su_cnt_q;
			slow_q <= slow_q | (su_busy & supply_low);
		end
	end

	// fault and warning flags
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sl_q <= 1'b0;
			ot_q <= 1'b0;
			lv_q <= 1'b0;
			oc_q <= 1'b0;
			rf_q <= 1'b0;
			crit_q <= 1'b0;
			warn_q <= 1'b0;
			conf_q <= 1'b0;
		end else if (clk_en) begin
			sl_q <= fsa_flag(sl_q, step_cause, ack_err);
			ot_q <= fsa_flag(ot_q, over_temp, ack_err);
			lv_q <= fsa_flag(lv_q, supply_low, ack_err);
			oc_q <= fsa_flag(oc_q, over_current, ack_err);
			rf_q <= fsa_flag(rf_q, ref_fail, ack_err);
			crit_q <= crit_q | critical;
			warn_q <= fsa_flag(warn_q, overload, ack_warn);
			conf_q <= (svc_q & ((ot_q & ~over_temp) | (oc_q & ~over_current))) | (conf_q & ~ack_conf);
		end
	end

	// firmware update sequencing
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			upd_q <= FSA_UPD_IDLE;
			restart_q <= 1'b0;
			ref_start_q <= 1'b0;
			ref_req_q <= 1'b0;
			refused_q <= 1'b0;
		end else if (clk_en) begin
			restart_q <= launch_ok;
			ref_start_q <= upd_ok_w;
			ref_req_q <= upd_ok_w | (ref_req_q & ~ref_done);
			refused_q <= (launch_w & refuse_w) | (refused_q & ~launch_ok);
			case (upd_q)
				FSA_UPD_IDLE: begin
					upd_q <= launch_ok ? FSA_UPD_WAIT : FSA_UPD_IDLE;
				end
				FSA_UPD_WAIT: begin
					upd_q <= upd_ok_w ? FSA_UPD_IDLE : FSA_UPD_WAIT;
				end
				default: begin
					upd_q <= FSA_UPD_IDLE;
				end
			endcase
		end
	end

	// lamp colour selection
	logic err_any;
	logic dev_bad;
	logic orange_w;
	logic red_d;
	logic green_d;
	assign err_any = sl_q | ot_q | lv_q | oc_q | rf_q | crit_q;
	assign dev_bad = (cfg_q[3:0] == FSA_DEV_NONE) | (cfg_q[3:0] == FSA_DEV_UNKNOWN) | (actuator_id != cfg_q[7:4]);
	assign orange_w = warn_q | dev_bad | conf_q | ref_req_q;
	assign red_d = slow_q ? ph : (err_any | orange_w) & ph;
	assign green_d = slow_q ? ~ph : ~err_any & ph;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lamp_red_q <= 1'b0;
			lamp_green_q <= 1'b0;
			error_out_q <= 1'b0;
		end else if (clk_en) begin
			lamp_red_q <= red_d;
			lamp_green_q <= green_d;
			error_out_q <= auto_w & err_any;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign lamp_red = lamp_red_q;
	assign lamp_green = lamp_green_q;
	assign error_out = error_out_q;
	assign error_led = error_out_q;
	assign restart_req = restart_q;
	assign ref_run_start = ref_start_q;

	default clocking cb @(posedge clock iff clk_en);
	endclocking
	default disable iff (!rst_n);

	sequence s_launch;
		launch_ok ##1 restart_q;
	endsequence
	sequence s_wait_ok;
		(upd_q == FSA_UPD_WAIT) && upd_ok_w;
	endsequence

	red_on_err_a: assert property (err_any && !slow_q && ph |=> lamp_red && !lamp_green) else $error("error not red");
	err_out_a: assert property (auto_w && err_any |=> error_out && error_led) else $error("error output missing");
	manual_quiet_a: assert property (!auto_w |=> !error_out) else $error("error output in manual");
	green_ok_a: assert property (!err_any && !orange_w && !slow_q && ph |=> lamp_green && !lamp_red) else $error("idle not green");
	orange_a: assert property (orange_w && !err_any && !slow_q && ph |=> lamp_red && lamp_green) else $error("warning not orange");
	warn_hold_a: assert property (warn_q && !ack_warn |=> warn_q) else $error("warning dropped");
	alt_flash_a: assert property (slow_q |=> lamp_red != lamp_green) else $error("start-up low not alternating");
	lowv_set_a: assert property (supply_low |=> lv_q) else $error("low power not latched");
	crit_keep_a: assert property (crit_q |=> crit_q [*2]) else $error("critical cleared");
	ack_clear_a: assert property (ot_q && ack_err && !over_temp |=> !ot_q) else $error("acknowledge ignored");
	step_ack_a: assert property (sl_q && ack_err |=> !sl_q) else $error("step loss not acknowledged");
	restart_seq_a: assert property (launch_ok |-> s_launch) else $error("no restart on launch");
	ref_start_a: assert property (s_wait_ok |=> ref_run_start && ref_req_q) else $error("no reference run");
	refuse_a: assert property (launch_w && refuse_w |=> !restart_req && refused_q) else $error("update not refused");
endmodule // fsa_top

// >>> verification/fsa_master_model.sv
// master controller model: drives the binary reset input
module fsa_master_model (
	input wire logic clock,
	input wire logic auto_ack,
	input wire logic kick,
	input wire logic error_out,
	output logic reset_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold_q = 0;
	initial reset_in = 1'b0;
	always @(posedge clock) begin
		if ((kick || (auto_ack && error_out)) && hold_q == 0) begin
			reset_in <= 1'b1;
			hold_q <= 6;
		end else if (hold_q > 0) begin
			hold_q <= hold_q - 1;
			if (hold_q <= 3) reset_in <= 1'b0;
		end
	end
endmodule // fsa_master_model

// >>> verification/tb_fault_status_and_acknowledge.sv
// self-checking bench for the fault status and acknowledge block
module tb_fault_status_and_acknowledge
	import fsa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] GRN = 32'h0000_0800;
	localparam logic [31:0] RED = 32'h0008_0000;
	localparam logic [31:0] ORG = 32'h0008_0808;
	localparam logic [31:0] ALT = 32'h0008_0800;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [31:0] paddr = FSA_ZERO, pwdata = FSA_ZERO, prdata;
	logic btn_open = 1'b0, btn_close = 1'b0, kick = 1'b0, auto_ack = 1'b0, reset_in;
	logic step_cmd = 1'b0, overload = 1'b0, critical = 1'b0, ref_done = 1'b0, step_fb = 1'b0, clk_en = 1'b1;
	logic [3:0] cause = 4'h0, actuator_id = 4'h0;
	logic lamp_red, lamp_green, error_out, error_led, restart_req, ref_run_start;
	int bad_count = 0, n_checks = 0, cyc = 0, n_rst = 0, n_ref = 0;
	always #10 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		n_rst += restart_req;
		n_ref += ref_run_start;
		if (cyc == 6000) begin
			bad_count++;
			report_and_stop();
		end
	end
	fsa_top #(.BLINK_HALF_CYC(4)) DUT (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .btn_open(btn_open),
		.btn_close(btn_close), .reset_in(reset_in), .supply_low(cause[1]), .step_cmd(step_cmd),
		.step_fb(step_fb), .over_temp(cause[0]), .over_current(cause[2]), .ref_fail(cause[3]),
		.ref_done(ref_done), .overload(overload), .critical(critical), .actuator_id(actuator_id),
		.lamp_red(lamp_red), .lamp_green(lamp_green), .error_out(error_out), .error_led(error_led),
		.restart_req(restart_req), .ref_run_start(ref_run_start));
	fsa_master_model MM (.clock(clock), .auto_ack(auto_ack), .kick(kick), .error_out(error_out),
		.reset_in(reset_in));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic apb(input logic w, input logic [7:0] off, input logic [31:0] d,
		output logic [31:0] rd, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h00_0000, off};
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		tick(1);
		while (pready !== 1'b1) begin
			n++;
			tick(1);
		end
		chk("pready wait", n, FSA_ZERO);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask
	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, off, d, x, e);
	endtask
	task automatic rs(output logic [31:0] v);
		logic e;
		apb(1'b0, FSA_STATUS_OFF, FSA_ZERO, v, e);
		v = v & 32'h0000_0fff;
	endtask
	task automatic press();
		btn_open <= 1'b1;
		btn_close <= 1'b1;
		tick(2);
		btn_open <= 1'b0;
		btn_close <= 1'b0;
		tick(4);
	endtask
	task automatic pulse_kick();
		kick <= 1'b1;
		tick(1);
		kick <= 1'b0;
		tick(8);
	endtask
	task automatic watch(output logic [31:0] v);
		int r, g, b;
		r = 0;
		g = 0;
		b = 0;
		repeat (16) begin
			@(posedge clock);
			#1;
			r += lamp_red;
			g += lamp_green;
			b += lamp_red & lamp_green;
		end
		v = {8'h00, r[7:0], g[7:0], b[7:0]};
		@(posedge clock);
	endtask
	task automatic s_lamp();
		logic [31:0] v;
		logic e;
		watch(v);
		chk("lamp no type", v, ORG);
		wr(FSA_CFG_OFF, 32'h0000_0001);
		apb(1'b0, FSA_CFG_OFF, FSA_ZERO, v, e);
		chk("cfg", v, 32'h0000_0001);
		apb(1'b0, 8'h40, FSA_ZERO, v, e);
		chk("unmapped", {31'h0, e}, 32'h0000_0001);
		watch(v);
		chk("lamp idle", v, GRN);
		actuator_id <= 4'h1;
		tick(2);
		watch(v);
		chk("lamp actuator", v, ORG);
		actuator_id <= 4'h0;
		clk_en <= 1'b0;
		overload <= 1'b1;
		tick(2);
		overload <= 1'b0;
		clk_en <= 1'b1;
		tick(2);
		rs(v);
		chk("frozen", v, FSA_ZERO);
	endtask
	task automatic s_errors();
		logic [31:0] v;
		for (int i = 0; i < 4; i++) begin
			cause <= 4'h1 << i;
			tick(1);
			cause <= 4'h0;
			tick(3);
			watch(v);
			chk("lamp error", v, RED);
			rs(v);
			chk("error flag", v, 32'h0000_0002 << i);
			chk("error out manual", {31'h0, error_out}, FSA_ZERO);
			press();
			rs(v);
			chk("button ack", v, FSA_ZERO);
		end
	endtask
	task automatic s_confirm();
		logic [31:0] v;
		cause <= 4'h1;
		tick(2);
		press();
		rs(v);
		chk("cause held", v, 32'h0000_0002);
		cause <= 4'h0;
		tick(1);
		wr(FSA_CMD_OFF, 32'h0000_0001);
		tick(3);
		rs(v);
		chk("confirmed", v, 32'h0000_0080);
		watch(v);
		chk("lamp confirmed", v, ORG);
		press();
		rs(v);
		chk("confirm cleared", v, FSA_ZERO);
	endtask
	task automatic s_step();
		logic [31:0] v;
		step_fb <= 1'b1;
		step_cmd <= 1'b1;
		tick(20);
		step_cmd <= 1'b0;
		step_fb <= 1'b0;
		tick(2);
		rs(v);
		chk("steps matched", v, FSA_ZERO);
		for (int i = 0; i < 17; i++) begin
			step_cmd <= 1'b1;
			tick(1);
			step_cmd <= 1'b0;
			tick(1);
			if (i == 15) begin
				tick(2);
				rs(v);
				chk("steps at limit", v, FSA_ZERO);
			end
		end
		tick(2);
		rs(v);
		chk("step loss", v, 32'h0000_0001);
		pulse_kick();
		rs(v);
		chk("reset input ack", v, FSA_ZERO);
	endtask
	task automatic s_auto();
		logic [31:0] v;
		wr(FSA_CTRL_OFF, 32'h0000_0001);
		overload <= 1'b1;
		tick(1);
		overload <= 1'b0;
		tick(3);
		watch(v);
		chk("lamp warning", v, ORG);
		press();
		rs(v);
		chk("warning kept", v, 32'h0000_0040);
		pulse_kick();
		rs(v);
		chk("warning reset", v, FSA_ZERO);
		auto_ack <= 1'b1;
		cause <= 4'h4;
		tick(1);
		cause <= 4'h0;
		for (int n = 0; n < 10 && error_out !== 1'b1; n++) tick(1);
		chk("error out", {31'h0, error_out}, 32'h0000_0001);
		chk("error led", {31'h0, error_led}, 32'h0000_0001);
		for (int n = 0; n < 30 && error_out !== 1'b0; n++) tick(1);
		auto_ack <= 1'b0;
		tick(8);
		rs(v);
		chk("master ack", v, FSA_ZERO);
		cause <= 4'h4;
		wr(FSA_CMD_OFF, 32'h0000_0001);
		rs(v);
		chk("error recurs", v, 32'h0000_0008);
		wr(FSA_CTRL_OFF, FSA_ZERO);
		cause <= 4'h0;
		wr(FSA_CMD_OFF, 32'h0000_0001);
		tick(1);
		rs(v);
		chk("manual re-ack", v, 32'h0000_0080);
		chk("error out off", {31'h0, error_out}, FSA_ZERO);
		press();
	endtask
	task automatic s_update();
		logic [31:0] v;
		logic e;
		wr(FSA_CTRL_OFF, 32'h0000_0002);
		apb(1'b1, FSA_CMD_OFF, 32'h0000_0002, v, e);
		chk("launch refused", {31'h0, e}, 32'h0000_0001);
		rs(v);
		chk("refused flag", v, 32'h0000_0400);
		chk("no restart", n_rst, FSA_ZERO);
		wr(FSA_LEVEL_OFF, 32'h0000_0003);
		wr(FSA_CMD_OFF, 32'h0000_0002);
		rs(v);
		chk("update waiting", v, 32'h0000_0800);
		chk("restart pulse", n_rst, 32'h0000_0001);
		wr(FSA_CMD_OFF, 32'h0000_0004);
		tick(1);
		chk("ref run pulse", n_ref, 32'h0000_0001);
		rs(v);
		chk("ref required", v, 32'h0000_0100);
		watch(v);
		chk("lamp ref run", v, ORG);
		ref_done <= 1'b1;
		tick(1);
		ref_done <= 1'b0;
		tick(2);
		rs(v);
		chk("ref done", v, FSA_ZERO);
	endtask
	task automatic s_crit();
		logic [31:0] v;
		critical <= 1'b1;
		tick(1);
		critical <= 1'b0;
		tick(3);
		press();
		wr(FSA_CMD_OFF, 32'h0000_0001);
		pulse_kick();
		rs(v);
		chk("critical kept", v, 32'h0000_0020);
		watch(v);
		chk("lamp critical", v, RED);
		rst_n <= 1'b0;
		cause <= 4'h2;
		tick(3);
		rst_n <= 1'b1;
		tick(20);
		cause <= 4'h0;
		tick(3);
		rs(v);
		chk("startup low", v, 32'h0000_0204);
		watch(v);
		chk("lamp alternate", v, ALT);
	endtask
	initial begin
		tick(3);
		rst_n <= 1'b1;
		tick(2);
		s_lamp();
		tick(1100);
		s_errors();
		s_confirm();
		s_step();
		s_auto();
		s_update();
		s_crit();
		report_and_stop();
	end
endmodule // tb_fault_status_and_acknowledge
